/* File: core/mbhc_pkg.sv */
// Types shared by the modem buffer block and its bench.
package mbhc_pkg;

   // Events and data from the modem core, sampled on link clock edges.
   typedef struct packed {
      logic pre_det;
      logic hdr_ok;
      logic hdr_bad;
      logic byte_vld;
      logic pkt_end;
      logic tx_take;
      logic [7:0] hdr_len;
      logic [7:0] rx_byte;
   } mbhc_link_in_t;

   // Packet phase of the modem path.
   typedef enum logic [1:0] {PH_IDLE, PH_PRE, PH_HDR, PH_PAY} mbhc_phase_t;

endpackage : mbhc_pkg

/* File: core/mbhc_regs.svh */
// Register offsets, field positions, reset values and codes of the modem buffer block.
`ifndef MBHC_REGS_SVH
`define MBHC_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets.
// ------------------------------------------------------------
`define MBHC_OFS_DATA 8'h00
`define MBHC_OFS_PTR 8'h04
`define MBHC_OFS_TXBASE 8'h08
`define MBHC_OFS_RXBASE 8'h0c
`define MBHC_OFS_RXSTART 8'h10
`define MBHC_OFS_RXCOUNT 8'h14
`define MBHC_OFS_OPMODE 8'h18
`define MBHC_OFS_TXCFG1 8'h1c
`define MBHC_OFS_HOPPER 8'h20
`define MBHC_OFS_HOPSTAT 8'h24
`define MBHC_OFS_PAYLEN 8'h28
`define MBHC_OFS_HDRCFG 8'h2c

// ------------------------------------------------------------
// Field positions.
// ------------------------------------------------------------
`define MBHC_OPMODE_SEL_BIT 7
`define MBHC_TXCFG1_HOP_BIT 0
`define MBHC_HDRCFG_IMPL_BIT 0
`define MBHC_HOPSTAT_IRQ_BIT 7

// ------------------------------------------------------------
// Reset values.
// ------------------------------------------------------------
`define MBHC_RST_TXBASE 8'h80
`define MBHC_RST_RXBASE 8'h00
`define MBHC_RST_PAYLEN 8'h01

// ------------------------------------------------------------
// Operating mode codes of the mode field.
// ------------------------------------------------------------
`define MBHC_MODE_SLEEP 3'h0
`define MBHC_MODE_STDBY 3'h1
`define MBHC_MODE_TX_SYNTH_MODE 3'h2
`define MBHC_MODE_TX 3'h3
`define MBHC_MODE_RX_SYNTH_MODE 3'h4
`define MBHC_MODE_RXCONT 3'h5
`define MBHC_MODE_RX_SINGLE_MODE 3'h6
`define MBHC_MODE_CAD 3'h7

`endif

/* File: core/mbhc_top.sv */
// Packet buffer, hop control and operating mode control of the long range modem.
`timescale 1ns/1ps
`include "mbhc_regs.svh"

module mbhc_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic link_clk_i,
   input wire mbhc_pkg::mbhc_link_in_t link_i,
   output logic [7:0] tx_byte_o,
   output logic [2:0] mode_o,
   output logic hop_irq_o,
   output logic hop_pulse_o
);

   // ------------------------------------------------------------
   // Link synchronisers and symbol edge detection.
   // ------------------------------------------------------------
   logic lclk_s1_q, lclk_s2_q, lclk_s3_q;
   mbhc_pkg::mbhc_link_in_t lin_s1_q, lin_s2_q;
   wire sym_edge = lclk_s2_q & ~lclk_s3_q;

   // The first stage feeds only the second; edges are seen between stages two and three.
   always_ff @(posedge clk_i)
   begin
      lclk_s1_q <= link_clk_i;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
      lin_s1_q <= link_i;
      lin_s2_q <= lin_s1_q;
   end

   // Modem events count only on a link edge.
   wire ev_pre = sym_edge & lin_s2_q.pre_det;
   wire ev_hok = sym_edge & lin_s2_q.hdr_ok;
   wire ev_hbad = sym_edge & lin_s2_q.hdr_bad;
   wire ev_byte = sym_edge & lin_s2_q.byte_vld;
   wire ev_end = sym_edge & lin_s2_q.pkt_end;
   wire ev_take = sym_edge & lin_s2_q.tx_take;

   // ------------------------------------------------------------
   // Registers and state.
   // ------------------------------------------------------------
   logic [7:0] mem_q [256];
   logic [7:0] ptr_q, txbase_q, rxbase_q, rxstart_q, rxcount_q;
   logic [7:0] hop_per_q, paylen_q, wptr_q, rptr_q, hop_sym_q;
   logic [5:0] hop_chan_q;
   logic [2:0] mode_q;
   logic sel_q, hop_en_q, impl_q, hop_irq_q, ack_q, hop_pulse_q;
   logic [31:0] rdat_q;
   logic [7:0] txb_q;
   mbhc_pkg::mbhc_phase_t ph_q, ph_d;

   // ------------------------------------------------------------
   // Bus decode.
   // ------------------------------------------------------------
   wire req = cyc_i & stb_i;
   wire wr_go = req & we_i & ack_q & sel_i[0];
   wire rd_go = req & ~we_i & ack_q;
   wire a_data = adr_i == `MBHC_OFS_DATA;
   wire a_ptr = adr_i == `MBHC_OFS_PTR;
   wire a_txb = adr_i == `MBHC_OFS_TXBASE;
   wire a_rxb = adr_i == `MBHC_OFS_RXBASE;
   wire a_mode = adr_i == `MBHC_OFS_OPMODE;
   wire a_cfg1 = adr_i == `MBHC_OFS_TXCFG1;
   wire a_hper = adr_i == `MBHC_OFS_HOPPER;
   wire a_hst = adr_i == `MBHC_OFS_HOPSTAT;
   wire a_plen = adr_i == `MBHC_OFS_PAYLEN;
   wire a_hcfg = adr_i == `MBHC_OFS_HDRCFG;
   wire [7:0] wb = dat_i[7:0];
   wire in_sleep = mode_q == `MBHC_MODE_SLEEP;
   wire buf_ok = sel_q & ~in_sleep;
   wire dp_go = (wr_go | rd_go) & a_data & buf_ok;
   wire mode_wr = wr_go & a_mode;
   wire [2:0] mode_new = wb[2:0];

   // Read data is chosen by an else-if chain; unmapped offsets read zero.
   logic [7:0] rsel;
   always_comb
   begin
      if (a_data)
         rsel = buf_ok ? mem_q[ptr_q] : 8'h00;
      else if (a_ptr)
         rsel = ptr_q;
      else if (a_txb)
         rsel = txbase_q;
      else if (a_rxb)
         rsel = rxbase_q;
      else if (adr_i == `MBHC_OFS_RXSTART)
         rsel = rxstart_q;
      else if (adr_i == `MBHC_OFS_RXCOUNT)
         rsel = rxcount_q;
      else if (a_mode)
         rsel = {sel_q, 4'h0, mode_q};
      else if (a_cfg1)
         rsel = {7'h00, hop_en_q};
      else if (a_hper)
         rsel = hop_per_q;
      else if (a_hst)
         rsel = {hop_irq_q, 1'b0, hop_chan_q};
      else if (a_plen)
         rsel = paylen_q;
      else if (a_hcfg)
         rsel = {7'h00, impl_q};
      else
         rsel = 8'h00;
   end

   // Ack rises one cycle after the request and drops the cycle after.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= req & ~ack_q;
         rdat_q <= {24'h00_0000, rsel};
      end
   end
   assign ack_o = ack_q;
   assign dat_o = rdat_q;

   // ------------------------------------------------------------
   // Configuration registers.
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         txbase_q <= `MBHC_RST_TXBASE;
         rxbase_q <= `MBHC_RST_RXBASE;
         hop_en_q <= 1'b0;
         hop_per_q <= 8'h00;
         paylen_q <= `MBHC_RST_PAYLEN;
         impl_q <= 1'b0;
         sel_q <= 1'b0;
      end
      else
      begin
         if (wr_go & a_txb) txbase_q <= wb;
         if (wr_go & a_rxb) rxbase_q <= wb;
         if (wr_go & a_cfg1) hop_en_q <= wb[`MBHC_TXCFG1_HOP_BIT];
         if (wr_go & a_hper) hop_per_q <= wb;
         if (wr_go & a_plen) paylen_q <= wb;
         if (wr_go & a_hcfg) impl_q <= wb[`MBHC_HDRCFG_IMPL_BIT];
         if (mode_wr & in_sleep) sel_q <= wb[`MBHC_OPMODE_SEL_BIT];
      end
   end

   // ------------------------------------------------------------
   // Operating mode: host writes it, transmit and single receive packet ends return to standby.
   // ------------------------------------------------------------
   wire tx_done = mode_q == `MBHC_MODE_TX && ev_end;
   wire rxs_done = mode_q == `MBHC_MODE_RX_SINGLE_MODE && ev_end;
   wire is_rx = mode_q == `MBHC_MODE_RXCONT || mode_q == `MBHC_MODE_RX_SINGLE_MODE;
   wire is_tx = mode_q == `MBHC_MODE_TX;
   wire enter_rx = mode_wr & ~is_rx &
      (mode_new == `MBHC_MODE_RXCONT || mode_new == `MBHC_MODE_RX_SINGLE_MODE);
   wire enter_tx = mode_wr & ~is_tx & mode_new == `MBHC_MODE_TX;
   wire enter_sleep = mode_wr & ~in_sleep & mode_new == `MBHC_MODE_SLEEP;

   // A host write wins over an automatic return in the same cycle.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mode_q <= `MBHC_MODE_STDBY;
      else if (mode_wr)
         mode_q <= mode_new;
      else if (tx_done | rxs_done)
         mode_q <= `MBHC_MODE_STDBY;
   end
   assign mode_o = mode_q;

   // ------------------------------------------------------------
   // Access pointer and modem pointers.
   // ------------------------------------------------------------
   // The access pointer is 8 bits wide, so it wraps naturally.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ptr_q <= 8'h00;
      else if (wr_go & a_ptr)
         ptr_q <= wb;
      else if (dp_go)
         ptr_q <= ptr_q + 8'h01;
   end

   // Receive pointer restarts at the receive base on entering reception only;
   // in continuous mode packets follow each other with no reset.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wptr_q <= 8'h00;
         rxstart_q <= 8'h00;
         rxcount_q <= 8'h00;
         rptr_q <= 8'h00;
         txb_q <= 8'h00;
      end
      else
      begin
         if (enter_rx)
            wptr_q <= rxbase_q;
         else if (is_rx & ev_byte & ph_q == mbhc_pkg::PH_PAY)
            wptr_q <= wptr_q + 8'h01;
         if (is_rx & ev_hok & ph_q == mbhc_pkg::PH_HDR)
         begin
            rxstart_q <= wptr_q;
            rxcount_q <= impl_q ? paylen_q : lin_s2_q.hdr_len;
         end
         if (enter_tx)
            rptr_q <= txbase_q;
         else if (is_tx & ev_take)
            rptr_q <= rptr_q + 8'h01;
         txb_q <= mem_q[rptr_q];
      end
   end
   assign tx_byte_o = txb_q;

   // ------------------------------------------------------------
   // Buffer storage.
   // ------------------------------------------------------------
   // The whole array clears in one cycle on entering sleep; this costs area
   // but leaves no window where stale data could be read.
   wire rx_wr = is_rx & ev_byte & ph_q == mbhc_pkg::PH_PAY & sel_q;
   wire host_wr = dp_go & we_i;
   always_ff @(posedge clk_i)
   begin
      if (rst_i | enter_sleep)
      begin
         for (int i = 0; i < 256; i++)
            mem_q[i] <= 8'h00;
      end
      else
      begin
         if (host_wr)
            mem_q[ptr_q] <= wb;
         if (rx_wr)
            mem_q[wptr_q] <= lin_s2_q.rx_byte;
      end
   end

   // ------------------------------------------------------------
   // Packet phase.
   // ------------------------------------------------------------
   wire active = is_rx | is_tx;
   always_comb
   begin
      ph_d = ph_q;
      case (ph_q)
         mbhc_pkg::PH_IDLE:
            if (active) ph_d = is_tx ? mbhc_pkg::PH_HDR : mbhc_pkg::PH_PRE;
         mbhc_pkg::PH_PRE:
            if (ev_pre) ph_d = mbhc_pkg::PH_HDR;
         mbhc_pkg::PH_HDR:
            if (ev_hbad) ph_d = mbhc_pkg::PH_PRE;
            else if (ev_hok) ph_d = mbhc_pkg::PH_PAY;
         mbhc_pkg::PH_PAY:
            if (ev_end) ph_d = is_tx ? mbhc_pkg::PH_IDLE : mbhc_pkg::PH_PRE;
         default:
            ph_d = mbhc_pkg::PH_IDLE;
      endcase
      if (!active || mode_wr) ph_d = mbhc_pkg::PH_IDLE;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ph_q <= mbhc_pkg::PH_IDLE;
      else
         ph_q <= ph_d;
   end

   // ------------------------------------------------------------
   // Hop sequencer.
   // ------------------------------------------------------------
   wire hopping = hop_en_q & hop_per_q != 8'h00 & ph_q == mbhc_pkg::PH_PAY;
   wire hop_now = hopping & sym_edge & hop_sym_q == hop_per_q - 8'h01;
   wire hop_clr = wr_go & a_hst & wb[`MBHC_HOPSTAT_IRQ_BIT];

   // Channel returns to 0 whenever the modem is back outside the payload.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hop_sym_q <= 8'h00;
         hop_chan_q <= 6'h00;
         hop_irq_q <= 1'b0;
         hop_pulse_q <= 1'b0;
      end
      else
      begin
         hop_pulse_q <= hop_now;
         if (!hopping)
            hop_sym_q <= 8'h00;
         else if (hop_now)
            hop_sym_q <= 8'h00;
         else if (sym_edge)
            hop_sym_q <= hop_sym_q + 8'h01;
         if (ph_q != mbhc_pkg::PH_PAY)
            hop_chan_q <= 6'h00;
         else if (hop_now)
            hop_chan_q <= hop_chan_q + 6'h01;
         if (hop_now)
            hop_irq_q <= 1'b1;
         else if (hop_clr)
            hop_irq_q <= 1'b0;
      end
   end
   assign hop_irq_o = hop_irq_q;
   assign hop_pulse_o = hop_pulse_q;

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_hop_needs_en: assert property (hop_pulse_o |-> $past(hop_en_q))
      else $error("hop without hop enable");
   a_hop_dwell: assert property (hop_now |-> hop_sym_q == hop_per_q - 8'h01)
      else $error("hop off the dwell count");
   a_hop_chan_inc: assert property (hop_now |=> hop_chan_q == $past(hop_chan_q) + 6'h01)
      else $error("channel count not advanced");
   a_hop_flag_set: assert property (hop_now |=> hop_irq_q && hop_pulse_o)
      else $error("hop flag not raised");
   a_hop_flag_clr: assert property (hop_clr && !hop_now |=> !hop_irq_q)
      else $error("hop flag not cleared");
   a_hdr_bad_ch0: assert property (ph_q == mbhc_pkg::PH_HDR && ev_hbad
      |=> ph_q == mbhc_pkg::PH_PRE ##1 hop_chan_q == 6'h00)
      else $error("header failure kept channel");
   a_pre_ch0: assert property (ph_q == mbhc_pkg::PH_PRE |=> hop_chan_q == 6'h00)
      else $error("channel moved before preamble");
   a_sel_in_sleep: assert property (!$stable(sel_q) |-> $past(in_sleep))
      else $error("modem select changed outside sleep");
   a_ptr_step: assert property (dp_go && !(wr_go && a_ptr)
      |=> ptr_q == $past(ptr_q) + 8'h01)
      else $error("access pointer did not advance");
   a_tx_to_stdby: assert property (tx_done && !mode_wr |=> mode_q == `MBHC_MODE_STDBY)
      else $error("transmit did not return to standby");
   a_rxc_stays: assert property (mode_q == `MBHC_MODE_RXCONT && !mode_wr
      |=> mode_q == `MBHC_MODE_RXCONT)
      else $error("continuous receive left by itself");
   a_rx_count: assert property (is_rx && ev_hok && !impl_q && ph_q == mbhc_pkg::PH_HDR
      |=> rxcount_q == $past(lin_s2_q.hdr_len))
      else $error("byte count not from header");
   a_sleep_clear: assert property (enter_sleep |=> mem_q[ptr_q] == 8'h00)
      else $error("buffer not cleared on sleep");

endmodule : mbhc_top

/* File: sim/mbhc_link_model.sv */
// Behavioural model of the modem core that feeds the link side of the buffer block.
`timescale 1ns/1ps

module mbhc_link_model (
   output logic link_clk_o,
   output mbhc_pkg::mbhc_link_in_t link_o
);
   // ------------------------------------------------------------
   // Symbol clock and event levels.
   // ------------------------------------------------------------
   // The symbol clock stands still between events, as a real core's would when idle.
   initial
   begin
      link_clk_o = 1'b0;
      link_o = '0;
   end

   // One event takes one full link period of 160 ns, with the rising edge in the middle.
   // Afterwards the events drop and the data lines show the inverse of the last value,
   // so that a stale byte can never be mistaken for a fresh one.
   task automatic send(input mbhc_pkg::mbhc_link_in_t ev);
      link_o = ev;
      #80 link_clk_o = 1'b1;
      #80 link_clk_o = 1'b0;
      link_o = {6'h00, ~ev.hdr_len, ~ev.rx_byte};
   endtask : send
endmodule : mbhc_link_model

/* File: sim/modem_buffer_hop_mode_ctrl_test.sv */
// Self-checking testbench of the modem buffer, hop and mode control block.
`timescale 1ns/1ps
`include "mbhc_regs.svh"

module modem_buffer_hop_mode_ctrl_test;
   `define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
      $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end

   localparam logic [5:0] E_PRE = 6'h20;
   localparam logic [5:0] E_HOK = 6'h10;
   localparam logic [5:0] E_HBAD = 6'h08;
   localparam logic [5:0] E_BYTE = 6'h04;
   localparam logic [5:0] E_END = 6'h02;
   localparam logic [5:0] E_TAKE = 6'h01;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic link_clk_i;
   mbhc_pkg::mbhc_link_in_t link_i;
   logic [7:0] tx_byte_o;
   logic [2:0] mode_o;
   logic hop_irq_o;
   logic hop_pulse_o;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   int pulses = 0;

   mbhc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .link_clk_i(link_clk_i), .link_i(link_i), .tx_byte_o(tx_byte_o), .mode_o(mode_o),
      .hop_irq_o(hop_irq_o), .hop_pulse_o(hop_pulse_o));
   mbhc_link_model u_link (.link_clk_o(link_clk_i), .link_o(link_i));

   // ------------------------------------------------------------
   // Clock, hop pulse counter and hang guard.
   // ------------------------------------------------------------
   always #10 clk_i = ~clk_i;

   // The whole run needs a few hundred cycles; the ceiling leaves ample margin.
   always @(posedge clk_i)
   begin
      cycles++;
      if (hop_pulse_o === 1'b1) pulses++;
      if (cycles == 20000)
      begin
         miscompares++;
         results();
      end
   end

   // ------------------------------------------------------------
   // Bus and link helpers.
   // ------------------------------------------------------------
   // Classic cycle: request held until ack is sampled, then released for one idle cycle.
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] r);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      // Register updates land at the acknowledged edge; wait one more edge so callers
      // never sample an output in the same time step that launches it.
      @(posedge clk_i);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, 4'hf, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      bus(1'b0, a, 8'h00, 4'hf, r);
      `CHK(r, {24'h0, e})
   endtask : rd

   task automatic ev(input logic [5:0] f, input logic [7:0] l, input logic [7:0] b);
      u_link.send({f, l, b});
   endtask : ev

   // ------------------------------------------------------------
   // Scenarios.
   // ------------------------------------------------------------
   // Reset values, then the buffer stays shut until the modem is selected in sleep.
   task automatic t_reset_select();
      logic [31:0] r;
      rd(`MBHC_OFS_TXBASE, 8'h80);
      rd(`MBHC_OFS_RXBASE, 8'h00);
      `CHK(mode_o, 3'h1)
      wr(`MBHC_OFS_OPMODE, 8'h81);
      rd(`MBHC_OFS_OPMODE, 8'h01);
      wr(`MBHC_OFS_DATA, 8'h5a);
      rd(`MBHC_OFS_PTR, 8'h00);
      wr(`MBHC_OFS_OPMODE, 8'h00);
      wr(`MBHC_OFS_OPMODE, 8'h80);
      rd(`MBHC_OFS_OPMODE, 8'h80);
      rd(`MBHC_OFS_DATA, 8'h00);
      wr(`MBHC_OFS_OPMODE, 8'h81);
      rd(8'h3c, 8'h00);
      bus(1'b1, `MBHC_OFS_DATA, 8'h77, 4'h0, r);
      rd(`MBHC_OFS_PTR, 8'h00);
   endtask : t_reset_select

   // Data port bursts wrap the access pointer from the last location to the first.
   task automatic t_pointer_wrap();
      wr(`MBHC_OFS_PTR, 8'hfe);
      wr(`MBHC_OFS_DATA, 8'ha1);
      wr(`MBHC_OFS_DATA, 8'ha2);
      wr(`MBHC_OFS_DATA, 8'ha3);
      rd(`MBHC_OFS_PTR, 8'h01);
      wr(`MBHC_OFS_PTR, 8'hfe);
      rd(`MBHC_OFS_DATA, 8'ha1);
      rd(`MBHC_OFS_DATA, 8'ha2);
      rd(`MBHC_OFS_DATA, 8'ha3);
   endtask : t_pointer_wrap

   // Single receive with hopping every two symbols; the packet overruns into the tx half.
   task automatic t_rx_hop();
      wr(`MBHC_OFS_TXCFG1, 8'h01);
      wr(`MBHC_OFS_HOPPER, 8'h02);
      wr(`MBHC_OFS_RXBASE, 8'h7f);
      wr(`MBHC_OFS_OPMODE, 8'h86);
      ev(E_PRE, 8'h00, 8'h00);
      ev(E_HOK, 8'h03, 8'h00);
      ev(E_BYTE, 8'h00, 8'hc1);
      rd(`MBHC_OFS_HOPSTAT, 8'h00);
      ev(E_BYTE, 8'h00, 8'hc2);
      rd(`MBHC_OFS_HOPSTAT, 8'h81);
      `CHK(hop_irq_o, 1'b1)
      `CHK(pulses, 1)
      wr(`MBHC_OFS_HOPSTAT, 8'h80);
      rd(`MBHC_OFS_HOPSTAT, 8'h01);
      ev(E_BYTE, 8'h00, 8'hc3);
      ev(E_END, 8'h00, 8'h00);
      rd(`MBHC_OFS_RXCOUNT, 8'h03);
      rd(`MBHC_OFS_RXSTART, 8'h7f);
      `CHK(mode_o, 3'h1)
      // The end edge completes a second dwell, so a second hop is flagged there.
      `CHK(pulses, 2)
      rd(`MBHC_OFS_HOPSTAT, 8'h80);
      wr(`MBHC_OFS_HOPSTAT, 8'h80);
      rd(`MBHC_OFS_HOPSTAT, 8'h00);
      wr(`MBHC_OFS_PTR, 8'h7f);
      rd(`MBHC_OFS_DATA, 8'hc1);
      rd(`MBHC_OFS_DATA, 8'hc2);
      rd(`MBHC_OFS_DATA, 8'hc3);
   endtask : t_rx_hop

   // A bad header sends the receiver back to preamble search on channel 0.
   task automatic t_bad_header();
      wr(`MBHC_OFS_OPMODE, 8'h85);
      ev(E_PRE, 8'h00, 8'h00);
      ev(E_HBAD, 8'h00, 8'h00);
      ev(E_HOK, 8'h04, 8'h00);
      ev(E_BYTE, 8'h00, 8'hd1);
      ev(E_BYTE, 8'h00, 8'hd2);
      rd(`MBHC_OFS_HOPSTAT, 8'h00);
      rd(`MBHC_OFS_RXCOUNT, 8'h03);
      `CHK(pulses, 2)
      ev(E_END, 8'h00, 8'h00);
      `CHK(mode_o, 3'h5)
   endtask : t_bad_header

   // Continuous receive with hopping off and an implicit header.
   task automatic t_no_hop_implicit();
      wr(`MBHC_OFS_OPMODE, 8'h81);
      wr(`MBHC_OFS_TXCFG1, 8'h00);
      wr(`MBHC_OFS_HDRCFG, 8'h01);
      wr(`MBHC_OFS_PAYLEN, 8'h05);
      wr(`MBHC_OFS_OPMODE, 8'h85);
      ev(E_PRE, 8'h00, 8'h00);
      ev(E_HOK, 8'h09, 8'h00);
      ev(E_BYTE, 8'h00, 8'he1);
      ev(E_BYTE, 8'h00, 8'he2);
      ev(E_BYTE, 8'h00, 8'he3);
      `CHK(pulses, 2)
      rd(`MBHC_OFS_RXCOUNT, 8'h05);
      ev(E_END, 8'h00, 8'h00);
      `CHK(mode_o, 3'h5)
      wr(`MBHC_OFS_OPMODE, 8'h81);
   endtask : t_no_hop_implicit

   // Transmit one packet from the tx base, then fall back to standby.
   task automatic t_transmit();
      wr(`MBHC_OFS_PTR, 8'h80);
      wr(`MBHC_OFS_DATA, 8'h11);
      wr(`MBHC_OFS_DATA, 8'h22);
      wr(`MBHC_OFS_OPMODE, 8'h83);
      repeat (3) @(posedge clk_i);
      `CHK(tx_byte_o, 8'h11)
      ev(E_HOK, 8'h00, 8'h00);
      ev(E_TAKE, 8'h00, 8'h00);
      `CHK(tx_byte_o, 8'h22)
      ev(E_END, 8'h00, 8'h00);
      `CHK(mode_o, 3'h1)
   endtask : t_transmit

   // Every mode code is accepted; contents survive until sleep clears them.
   task automatic t_modes_sleep();
      for (int i = 1; i < 8; i++)
      begin
         wr(`MBHC_OFS_OPMODE, 8'h80 | 8'(i));
         `CHK(mode_o, 3'(i))
      end
      wr(`MBHC_OFS_OPMODE, 8'h81);
      wr(`MBHC_OFS_PTR, 8'h80);
      rd(`MBHC_OFS_DATA, 8'h11);
      wr(`MBHC_OFS_OPMODE, 8'h80);
      `CHK(mode_o, 3'h0)
      wr(`MBHC_OFS_OPMODE, 8'h81);
      wr(`MBHC_OFS_PTR, 8'h80);
      rd(`MBHC_OFS_DATA, 8'h00);
   endtask : t_modes_sleep

   // ------------------------------------------------------------
   // Verdict and main sequence.
   // ------------------------------------------------------------
   task automatic results();
      if (miscompares == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results

   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset_select();
      t_pointer_wrap();
      t_rx_hop();
      t_bad_header();
      t_no_hop_implicit();
      t_transmit();
      t_modes_sleep();
      results();
   end
endmodule : modem_buffer_hop_mode_ctrl_test
